// ==== hdl/spss_consts.vh ====
// Constants for the status pin signal select block
// Function
// - Three status pins, each with 6-bit select
// - Shared-output pin valid only while chip deselected
// - Sleep forces low codes to polarity level, inverted level on the shared pin
// - Codes 0x20 and above work during sleep
// - Code 10 drives synthesizer lock detect
// - Code 11 serial clock, receive data on falling
// - Transmit data sampled on serial clock rising, or falling when pin 0 polarity is inverted
// - Code 12 synchronous receive data
// - Code 13 asynchronous receive data
// - Code 14 carrier sense above threshold
// - Code 15 CRC pass, cleared on receive entry
// - Codes 22, 23 demod bits one, zero
// - Code 29 symbol strobe
// - Code 27 transmit amplifier powerdown
// - Code 28 receive amplifier powerdown
`ifndef SPSS_CONSTS_VH
`define SPSS_CONSTS_VH
`define SPSS_SEL_W         6
`define SPSS_NPINS         3
`define SPSS_SHARED_PIN    1
`define SPSS_SLEEP_LIMIT   6'h20
`define SPSS_SEL_LOCK      6'h0a
`define SPSS_SEL_SCLK      6'h0b
`define SPSS_SEL_SDATA     6'h0c
`define SPSS_SEL_ADATA     6'h0d
`define SPSS_SEL_CS        6'h0e
`define SPSS_SEL_CRC       6'h0f
`define SPSS_SEL_HARD1     6'h16
`define SPSS_SEL_HARD0     6'h17
`define SPSS_SEL_PAPD      6'h1b
`define SPSS_SEL_LNAPD     6'h1c
`define SPSS_SEL_STROBE    6'h1d
`define SPSS_SEL_WAKEA     6'h24
`define SPSS_SEL_WAKEB     6'h25
`define SPSS_SEL_SLOWCLK   6'h27
`define SPSS_SEL_RDY       6'h29
`define SPSS_CFG_W         8
`define SPSS_CFG_INV_BIT   6
`define SPSS_ADDR_W        4
`define SPSS_REG_CFG0      4'h0
`define SPSS_REG_CFG1      4'h1
`define SPSS_REG_CFG2      4'h2
`define SPSS_REG_STAT      4'h3
`define SPSS_REG_CLR       4'h4
`define SPSS_REG_IEN       4'h5
`define SPSS_CFG_RST       8'h00
`define SPSS_EV_LOCK       0
`define SPSS_EV_CRC        1
`define SPSS_EV_CS         2
`define SPSS_EV_W          3
`endif

// ==== hdl/spss_pin_mux.v ====
// One status pin: select decode, sleep force and polarity inversion
`include "spss_consts.vh"
module spss_pin_mux #(
  parameter SHARED = 0
) (
  input  wire                   i_clk_sys,
  input  wire                   i_resetn,
  input  wire [`SPSS_SEL_W-1:0] i_sel,
  input  wire                   i_inv,
  input  wire                   i_sleep,
  input  wire                   i_osc_ready_low,
  input  wire                   i_lock,
  input  wire                   i_sclk,
  input  wire                   i_sdata,
  input  wire                   i_adata,
  input  wire                   i_carrier,
  input  wire                   i_crc,
  input  wire [1:0]             i_hard,
  input  wire                   i_strobe,
  input  wire                   i_tx_amp_powerdown,
  input  wire                   i_rx_amp_powerdown,
  input  wire                   i_wake_a,
  input  wire                   i_wake_b,
  input  wire                   i_slow_clk,
  output wire                   o_pin
);
  reg sel_d;
  reg pin_d;
  reg pin_q;
  reg hold_q;

  // Decode is local to this pin, no sharing across pins
  always @* begin
    case (i_sel)
      `SPSS_SEL_LOCK:    sel_d = i_lock;
      `SPSS_SEL_SCLK:    sel_d = i_sclk;
      `SPSS_SEL_SDATA:   sel_d = i_sdata;
      `SPSS_SEL_ADATA:   sel_d = i_adata;
      `SPSS_SEL_CS:      sel_d = i_carrier;
      `SPSS_SEL_CRC:     sel_d = i_crc;
      `SPSS_SEL_HARD1:   sel_d = i_hard[1];
      `SPSS_SEL_HARD0:   sel_d = i_hard[0];
      `SPSS_SEL_PAPD:    sel_d = i_tx_amp_powerdown;
      `SPSS_SEL_LNAPD:   sel_d = i_rx_amp_powerdown;
      `SPSS_SEL_STROBE:  sel_d = i_strobe;
      `SPSS_SEL_WAKEA:   sel_d = i_wake_a;
      `SPSS_SEL_WAKEB:   sel_d = i_wake_b;
      `SPSS_SEL_SLOWCLK: sel_d = i_slow_clk;
      `SPSS_SEL_RDY:     sel_d = i_osc_ready_low;
      // Reserved and out-of-range codes read low
      default:           sel_d = 1'b0;
    endcase
  end

  // Force holds from sleep until the ready indication drops low
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hold_q <= 1'b0;
    end else if (i_sleep) begin
      hold_q <= 1'b1;
    end else if (!i_osc_ready_low) begin
      hold_q <= 1'b0;
    end
  end

  always @* begin
    if ((i_sleep || hold_q) && i_sel < `SPSS_SLEEP_LIMIT) begin
      pin_d = (SHARED != 0) ? ~i_inv : i_inv;
    end else begin
      pin_d = sel_d ^ i_inv;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign o_pin = pin_q;
endmodule // spss_pin_mux

// ==== hdl/spss_top.v ====
// Status pin signal select: config registers, input sync, three pin muxes
`include "spss_consts.vh"
module spss_top (
  input  wire                    i_clk_sys,
  input  wire                    i_resetn,
  input  wire [`SPSS_ADDR_W-1:0] i_addr,
  input  wire [`SPSS_CFG_W-1:0]  i_wdata,
  input  wire                    i_wr,
  input  wire                    i_rd,
  output reg  [`SPSS_CFG_W-1:0]  o_rdata,
  output wire                    o_irq,
  input  wire                    i_chip_sel_n,
  input  wire                    i_so_data,
  input  wire                    i_sleep,
  input  wire                    i_osc_ready_low,
  input  wire                    i_lock,
  input  wire                    i_sclk,
  input  wire                    i_sdata,
  input  wire                    i_adata,
  input  wire                    i_carrier,
  input  wire                    i_crc_match,
  input  wire                    i_crc_valid,
  input  wire                    i_rx_enter,
  input  wire [1:0]              i_hard,
  input  wire                    i_strobe,
  input  wire                    i_tx_amp_powerdown,
  input  wire                    i_rx_amp_powerdown,
  input  wire                    i_wake_a,
  input  wire                    i_wake_b,
  input  wire                    i_slow_clk,
  output wire [`SPSS_NPINS-1:0]  o_status_pin,
  output wire [`SPSS_NPINS-1:0]  o_status_pin_oe,
  output wire                    o_tx_sample
);
  localparam NS = 16;
  // Chip select syncs from its deselected level so pin one starts on its mux
  localparam [NS-1:0] SYNC_RST = 16'h8000;

  reg  [`SPSS_CFG_W-1:0] cfg_q [0:`SPSS_NPINS-1];
  reg  [`SPSS_EV_W-1:0]  stat_q;
  reg  [`SPSS_EV_W-1:0]  ien_q;
  reg  [NS-1:0]          s1_q;
  reg  [NS-1:0]          s2_q;
  reg                    sclk_prev_q;
  reg                    lock_prev_q;
  reg                    cs_prev_q;
  reg                    crc_q;
  reg                    tx_sample_q;
  reg                    shared_q;
  wire [NS-1:0]          raw;
  wire [`SPSS_NPINS-1:0] mux_out;
  wire [`SPSS_EV_W-1:0]  ev;
  wire                   sclk_s;
  wire                   clr_wr;
  integer                k;

  assign raw = {i_chip_sel_n, i_sleep, i_osc_ready_low, i_lock, i_sclk, i_sdata,
                i_adata, i_carrier, i_hard, i_strobe, i_tx_amp_powerdown, i_rx_amp_powerdown,
                i_wake_a, i_wake_b, i_slow_clk};

  // Two-stage sync; only stage two is read by logic
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  assign sclk_s = s2_q[11];

  // CRC pass flag, cleared when receive starts; entry wins over a new result
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      crc_q <= 1'b0;
    end else if (i_rx_enter) begin
      crc_q <= 1'b0;
    end else if (i_crc_valid) begin
      crc_q <= i_crc_match;
    end
  end

  // Transmit data strobe on serial clock rising edge, inversion-aware
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sclk_prev_q <= 1'b0;
      tx_sample_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      tx_sample_q <= cfg_q[0][`SPSS_CFG_INV_BIT] ? (sclk_prev_q & ~sclk_s)
                                                 : (~sclk_prev_q & sclk_s);
    end
  end
  assign o_tx_sample = tx_sample_q;

  // Events: lock rise, each CRC pass result not in a receive entry cycle, carrier rise
  assign ev[`SPSS_EV_LOCK] = s2_q[12] & ~lock_prev_q;
  assign ev[`SPSS_EV_CRC]  = i_crc_valid & i_crc_match & ~i_rx_enter;
  assign ev[`SPSS_EV_CS]   = s2_q[8] & ~cs_prev_q;
  assign clr_wr = i_wr && (i_addr == `SPSS_REG_CLR);

  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      for (k = 0; k < `SPSS_NPINS; k = k + 1) begin
        cfg_q[k] <= `SPSS_CFG_RST;
      end
      stat_q      <= {`SPSS_EV_W{1'b0}};
      ien_q       <= {`SPSS_EV_W{1'b0}};
      lock_prev_q <= 1'b0;
      cs_prev_q   <= 1'b0;
      o_rdata     <= {`SPSS_CFG_W{1'b0}};
    end else begin
      lock_prev_q <= s2_q[12];
      cs_prev_q   <= s2_q[8];
      if (i_wr && i_addr == `SPSS_REG_CFG0) begin
        cfg_q[0] <= i_wdata;
      end
      if (i_wr && i_addr == `SPSS_REG_CFG1) begin
        cfg_q[1] <= i_wdata;
      end
      if (i_wr && i_addr == `SPSS_REG_CFG2) begin
        cfg_q[2] <= i_wdata;
      end
      if (i_wr && i_addr == `SPSS_REG_IEN) begin
        ien_q <= i_wdata[`SPSS_EV_W-1:0];
      end
      // Set wins over a same-cycle clear
      stat_q <= (stat_q & ~(clr_wr ? i_wdata[`SPSS_EV_W-1:0] : {`SPSS_EV_W{1'b0}})) | ev;
      o_rdata <= {`SPSS_CFG_W{1'b0}};
      if (i_rd) begin
        case (i_addr)
          `SPSS_REG_CFG0: o_rdata <= cfg_q[0];
          `SPSS_REG_CFG1: o_rdata <= cfg_q[1];
          `SPSS_REG_CFG2: o_rdata <= cfg_q[2];
          `SPSS_REG_STAT: o_rdata <= {{(`SPSS_CFG_W-`SPSS_EV_W){1'b0}}, stat_q};
          `SPSS_REG_IEN:  o_rdata <= {{(`SPSS_CFG_W-`SPSS_EV_W){1'b0}}, ien_q};
          default:        o_rdata <= {`SPSS_CFG_W{1'b0}};
        endcase
      end
    end
  end

  // Serial output owns the line while chip is selected; flopped like the other pins
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      shared_q <= 1'b0;
    end else begin
      shared_q <= s2_q[15] ? mux_out[`SPSS_SHARED_PIN] : i_so_data;
    end
  end

  // Host should take lock detect as an edge interrupt, not a single sample
  assign o_irq = |(stat_q & ien_q);

  genvar g;
  generate
    for (g = 0; g < `SPSS_NPINS; g = g + 1) begin : g_pin
      spss_pin_mux #(
        .SHARED (g == `SPSS_SHARED_PIN)
      ) u_mux (
        .i_clk_sys       (i_clk_sys),
        .i_resetn        (i_resetn),
        .i_sel           (cfg_q[g][`SPSS_SEL_W-1:0]),
        .i_inv           (cfg_q[g][`SPSS_CFG_INV_BIT]),
        .i_sleep         (s2_q[14]),
        .i_osc_ready_low (s2_q[13]),
        .i_lock          (s2_q[12]),
        .i_sclk          (sclk_s),
        .i_sdata         (s2_q[10]),
        .i_adata         (s2_q[9]),
        .i_carrier       (s2_q[8]),
        .i_crc           (crc_q),
        .i_hard          (s2_q[7:6]),
        .i_strobe        (s2_q[5]),
        .i_tx_amp_powerdown         (s2_q[4]),
        .i_rx_amp_powerdown        (s2_q[3]),
        .i_wake_a        (s2_q[2]),
        .i_wake_b        (s2_q[1]),
        .i_slow_clk      (s2_q[0]),
        .o_pin           (mux_out[g])
      );
      if (g == `SPSS_SHARED_PIN) begin : g_shared
        assign o_status_pin[g] = shared_q;
      end else begin : g_plain
        assign o_status_pin[g] = mux_out[g];
      end
      assign o_status_pin_oe[g] = 1'b1;
    end
  endgenerate
endmodule // spss_top

// ==== tb/spss_host_model.sv ====
// Host model: polls status pin 0 the way a microcontroller would
module spss_host_model (
  input  logic       i_clk_sys,
  input  logic [2:0] i_status_pin,
  output int         o_rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b0;
  initial o_rises = 0;
  // Lock counts as an edge event; one level sample could miss a short lock pulse
  always @(posedge i_clk_sys) begin
    if (i_status_pin[0] === 1'b1 && last_q === 1'b0) begin
      o_rises <= o_rises + 1;
    end
    last_q <= i_status_pin[0];
  end
endmodule // spss_host_model

// ==== tb/spss_top_chk.sv ====
// Assertion checker for the status pin select block
module spss_top_chk (
  input logic       i_clk_sys,
  input logic       i_resetn,
  input logic [3:0] i_addr,
  input logic [7:0] i_wdata,
  input logic       i_wr,
  input logic       i_rd,
  input logic [7:0] o_rdata,
  input logic       i_sleep,
  input logic       i_osc_ready_low,
  input logic       i_lock,
  input logic       i_carrier,
  input logic [1:0] i_hard,
  input logic       i_strobe,
  input logic       i_wake_a,
  input logic [2:0] o_status_pin,
  input logic       o_tx_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg_q;
  logic [2:0] age_q;
  wire        ok   = age_q > 3'h4;
  wire        inv  = cfg_q[6];
  wire  [5:0] code = cfg_q[5:0];
  // Settle count: pins lag config and sleep release through the sync pipeline
  always @(posedge i_clk_sys) begin
    if (!i_resetn || i_sleep || i_osc_ready_low) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
    if (!i_resetn) begin
      cfg_q <= 8'h00;
    end else if (i_wr && i_addr == 4'h0) begin
      cfg_q <= i_wdata;
      age_q <= 3'h0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_lock; ok && code == 6'h0a |-> o_status_pin[0] == ($past(i_lock, 3) ^ inv); endproperty
  a_lock: assert property (p_lock) else $error("pin0 not lock");
  property p_carr; ok && code == 6'h0e |-> o_status_pin[0] == ($past(i_carrier, 3) ^ inv); endproperty
  a_carr: assert property (p_carr) else $error("pin0 not carrier");
  property p_hard; ok && code == 6'h16 |-> o_status_pin[0] == ($past(i_hard, 3) >> 1 ^ inv); endproperty
  a_hard: assert property (p_hard) else $error("pin0 not demod bit");
  property p_strb; ok && code == 6'h1d |-> o_status_pin[0] == ($past(i_strobe, 3) ^ inv); endproperty
  a_strb: assert property (p_strb) else $error("pin0 not strobe");
  property p_wake; ok && code == 6'h24 |-> o_status_pin[0] == ($past(i_wake_a, 3) ^ inv); endproperty
  a_wake: assert property (p_wake) else $error("pin0 not wake");
  property p_slp;
    $past(i_sleep, 3) && $past(i_sleep, 4) && code < 6'h20 |-> o_status_pin[0] == inv;
  endproperty
  a_slp: assert property (p_slp) else $error("pin0 not forced");
  property p_rdz; !$past(i_rd) || $past(i_addr) > 4'h5 |-> o_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("idle read data");
  property p_rdb; $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata == $past(cfg_q); endproperty
  a_rdb: assert property (p_rdb) else $error("config readback");
  c_carr: cover property (ok && code == 6'h0e && $rose(o_status_pin[0]));
  c_slp: cover property ($past(i_sleep, 4) && code < 6'h20);
  c_tx: cover property (o_tx_sample);
endmodule // spss_top_chk

// ==== tb/testbench.sv ====
// Self-checking testbench for the status pin select block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, wr, rd, csn, so, slp, crcm, crcv, rxe;
  logic [3:0]  addr;
  logic [7:0]  wdata, rd_v;
  logic [13:0] sig;
  wire  [7:0]  rdata;
  wire  [2:0]  pin, pin_oe;
  wire         irq, txs;
  int          error_cnt, tests_run, rises, n, ntx, m;
  logic [7:0]  codes [14] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h17, 8'h16,
                              8'h1d, 8'h1b, 8'h1c, 8'h24, 8'h25, 8'h27, 8'h29};
  spss_top dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_chip_sel_n(csn), .i_so_data(so),
    .i_sleep(slp), .i_osc_ready_low(sig[13]), .i_lock(sig[0]), .i_sclk(sig[1]),
    .i_sdata(sig[2]), .i_adata(sig[3]), .i_carrier(sig[4]), .i_crc_match(crcm),
    .i_crc_valid(crcv), .i_rx_enter(rxe), .i_hard(sig[6:5]), .i_strobe(sig[7]),
    .i_tx_amp_powerdown(sig[8]), .i_rx_amp_powerdown(sig[9]), .i_wake_a(sig[10]), .i_wake_b(sig[11]),
    .i_slow_clk(sig[12]), .o_status_pin(pin), .o_status_pin_oe(pin_oe), .o_tx_sample(txs));
  spss_host_model host_u (.i_clk_sys(clk), .i_status_pin(pin), .o_rises(rises));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (txs === 1'b1) ntx <= ntx + 1;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Strobe drops on the sampling edge, then one idle edge keeps back-to-back calls legal
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) rd_v = rdata;
  endtask
  task automatic pulse_crc(input logic enter);
    crcv <= !enter;
    crcm <= !enter;
    rxe <= enter;
    @(posedge clk);
    {crcv, crcm, rxe} <= 3'b000;
    w(6);
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rstn, wr, rd, so, slp, crcm, crcv, rxe, csn} = 9'h001;
    addr = 4'h0;
    wdata = 8'h00;
    sig = 14'h0;
    {error_cnt, tests_run, ntx} = 0;
    w(5);
    rstn <= 1'b1;
    w(1);
    chk("pins after reset", pin, 8'h00);
    wr_reg(4'h1, 8'h0e);
    wr_reg(4'h2, 8'h4e);
    rd_reg(4'h2);
    chk("cfg2 readback", rd_v, 8'h4e);
    rd_reg(4'hf);
    chk("unmapped read", rd_v, 8'h00);
    for (int k = 0; k < 14; k++) begin
      wr_reg(4'h0, {1'b0, k[0], codes[k][5:0]});
      for (int v = 0; v < 2; v++) begin
        sig[k] <= v[0];
        w(6);
        chk("pin0 route", pin[0], v[0] ^ k[0]);
        chk("pin2 inverted carrier", pin[2], !sig[4]);
      end
      sig[k] <= 1'b0;
    end
    wr_reg(4'h0, 8'h0b);
    rd_reg(4'h0);
    chk("cfg0 readback", rd_v, 8'h0b);
    {n, m} = {rises, ntx};
    repeat (8) begin
      sig[1] <= 1'b1;
      w(6);
      sig[1] <= 1'b0;
      w(7);
    end
    chk("serial clock edges", rises - n, 8'h08);
    chk("tx sample pulses", ntx - m, 8'h08);
    wr_reg(4'h0, 8'h0f);
    wr_reg(4'h4, 8'h07);
    pulse_crc(1'b0);
    chk("crc pass pin", pin[0], 8'h01);
    chk("irq masked", irq, 8'h00);
    wr_reg(4'h3, 8'hff);
    rd_reg(4'h3);
    chk("status", rd_v, 8'h02);
    wr_reg(4'h5, 8'h02);
    chk("irq enabled", irq, 8'h01);
    pulse_crc(1'b1);
    chk("crc cleared on rx entry", pin[0], 8'h00);
    wr_reg(4'h4, 8'h02);
    w(1);
    chk("irq cleared", irq, 8'h00);
    csn <= 1'b0;
    so <= 1'b1;
    w(6);
    chk("pin1 serial out", pin[1], 8'h01);
    csn <= 1'b1;
    w(6);
    chk("pin1 deselected", pin[1], 8'h00);
    wr_reg(4'h2, 8'h24);
    {slp, sig[13], sig[10], sig[4]} <= 4'he;
    w(6);
    chk("sleep pins", pin, 8'h06);
    slp <= 1'b0;
    w(6);
    chk("held until ready", pin, 8'h06);
    sig[13] <= 1'b0;
    w(6);
    chk("awake pins", pin, 8'h04);
    chk("pin enables", pin_oe, 8'h07);
    stop_test;
  end
  initial begin
    w(20000);
    error_cnt++;
    stop_test;
  end
endmodule // testbench
bind spss_top spss_top_chk chk_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
  .i_osc_ready_low(i_osc_ready_low), .i_lock(i_lock), .i_carrier(i_carrier), .i_hard(i_hard),
  .i_strobe(i_strobe), .i_wake_a(i_wake_a), .o_status_pin(o_status_pin),
  .o_tx_sample(o_tx_sample));
